// ---- shared/proc_status_regs.vh ----
// Constants for the processor status and exception gating block.
// Assumes inclusion by bare name from design and bench files.
`ifndef PROC_STATUS_REGS_VH
`define PROC_STATUS_REGS_VH
// ----------------------------------------------------------------------------
// Status register fields
// ----------------------------------------------------------------------------
`define PSC_BIT_TIMER_BLOCK   17
`define PSC_BIT_PENDING       14
`define PSC_BIT_STEP_EN       13
`define PSC_BIT_STEP_PEND     12
`define PSC_BIT_ALIGN         11
`define PSC_BIT_HOLD          10
`define PSC_BIT_WAIT          7
`define PSC_BIT_PRIV          4
`define PSC_BIT_MASK_HI       3
`define PSC_BIT_MASK_LO       2
`define PSC_BIT_IRQ_BLOCK     1
`define PSC_BIT_BLOCK_ALL     0
`define PSC_WRITE_MASK        32'h00023C9F
`define PSC_RESET_VALUE       32'h00000413
// ----------------------------------------------------------------------------
// Vector numbers
// ----------------------------------------------------------------------------
`define VEC_UNALIGNED         8'h01
`define VEC_PROTECT           8'h05
`define VEC_TIMER             8'h0E
`define VEC_TRACE             8'h0F
`define VEC_EXT_ZERO          8'h10
`define VEC_EXT_TWO           8'h12
`define VEC_INTERNAL          8'h13
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define HOLD_RELEASE_CYCLES   2
`endif

// ---- rtl/proc_status_gating.v ----
// Processor status register and interrupt/trap gating of a small RISC core.
// Assumes all inputs synchronous to CLK_SYS_IN; pipeline honours the take pulse.
//
// How it works
// - Timer irq blocked by timer block bit, else follows reload irq enable.
// - Block-all bit blocks timer irq regardless of other enables.
// - Pending flag reads 1 when an external or internal irq request is active and none of them is enabled.
// - Pending flag clears itself once all requests drop.
// - Step enable copied into step pending at each instruction completion while wait bit clear, unless an event is taken.
// - Step pending of 1 raises a trace trap.
// - Align check flags unaligned word or halfword external data accesses.
// - No align check on I/O or fetch; vectors formed aligned.
// - Hold bit freezes channel, counters and ALU status except explicit moves.
// - Hold bit set on every taken interrupt or trap.
// - After hold clears, taking waits two cycles; setting acts at once.
// - Wait bit stalls execution until enabled event taken or reset.
// - User level access to protected context raises protection trap.
// - Mask 00/01 zero only, 10 adds two, 11 adds internal.
// - External irq zero never masked by priority mask.
// - Irq block stops peripheral/external irqs, not traps, timer or trace.
// - Irq block clear takes mask-enabled irqs unless block-all set.
// - Block-all ignores interrupts and traps; clear takes every trap.
// - Only external irq inputs zero and two exist.
// - No automatic state save; dispatch through relocatable vector table.
// - Vector number placed into bits 9..2 of vector base address.
`timescale 1ns/1ps
`include "proc_status_regs.vh"
module proc_status_gating (
  // Clock and reset
  input  wire        CLK_SYS_IN,
  input  wire        RESET_IN,
  // Software access to the status register
  input  wire        PSC_WRITE_IN,
  input  wire [31:0] PSC_WDATA_IN,
  output reg  [31:0] PSC_RDATA_OUT,
  // Requests
  input  wire        EXT_IRQ_ZERO_IN,
  input  wire        EXT_IRQ_TWO_IN,
  input  wire        INT_IRQ_IN,
  input  wire        TIMER_IRQ_IN,
  input  wire        TIMER_RELOAD_IRQ_ENABLE_IN,
  // Pipeline events
  input  wire        INSTR_DONE_IN,
  input  wire        DATA_ACCESS_IN,
  input  wire        DATA_IO_IN,
  input  wire        DATA_WORD_IN,
  input  wire        DATA_HALF_IN,
  input  wire [1:0]  DATA_ADDR_LO_IN,
  input  wire        PROTECTED_ACCESS_IN,
  input  wire [31:0] VECTOR_BASE_IN,
  // Outputs to pipeline
  output reg         TAKE_OUT,
  output reg  [7:0]  VECTOR_NUM_OUT,
  output reg  [31:0] VECTOR_ADDR_OUT,
  output reg         STATE_HOLD_OUT,
  output reg         STALL_OUT
);

  // --------------------------------------------------------------------------
  // Status fields
  // --------------------------------------------------------------------------
  reg        timer_irq_block_q;
  reg        irq_pending_flag_q;
  reg        single_step_enable_q;
  reg        single_step_pending_q;
  reg        align_check_enable_q;
  reg        state_hold_q;
  reg        idle_wait_q;
  reg        privileged_level_q;
  reg [1:0]  irq_priority_mask_q;
  reg        irq_block_q;
  reg        irq_trap_block_all_q;
  reg [1:0]  release_cnt_q;

  // Vector address: number in bits 9..2, base in bits 31..10, bits 1..0 zero
  function [31:0] vec_addr;
    input [31:0] base;
    input [7:0]  num;
    begin
      vec_addr = {base[31:10], num, 2'b00};
    end
  endfunction

  // --------------------------------------------------------------------------
  // Gating
  // --------------------------------------------------------------------------
  wire mask_two = irq_priority_mask_q[1];
  wire mask_int = (irq_priority_mask_q == 2'b11);
  wire irq_ok   = !irq_block_q && !irq_trap_block_all_q;
  wire en_zero  = EXT_IRQ_ZERO_IN && irq_ok;
  wire en_two   = EXT_IRQ_TWO_IN && mask_two && irq_ok;
  wire en_int   = INT_IRQ_IN && mask_int && irq_ok;
  wire en_timer = TIMER_IRQ_IN && !timer_irq_block_q &&
                  TIMER_RELOAD_IRQ_ENABLE_IN && !irq_trap_block_all_q;
  wire any_req  = EXT_IRQ_ZERO_IN || EXT_IRQ_TWO_IN || INT_IRQ_IN;
  wire pend_d   = any_req && !(en_zero || en_two || en_int);

  // Alignment only for external data, never I/O or fetch
  wire unaligned = align_check_enable_q && DATA_ACCESS_IN && !DATA_IO_IN &&
                   ((DATA_WORD_IN && (DATA_ADDR_LO_IN != 2'b00)) ||
                    (DATA_HALF_IN && DATA_ADDR_LO_IN[0]));
  wire protect   = !privileged_level_q && PROTECTED_ACCESS_IN;
  wire trap_ok   = !irq_trap_block_all_q;
  // Settling window after hold release blocks taking
  wire settled   = (release_cnt_q == 2'd0);

  reg       take_d;
  reg [7:0] vec_d;
  always @* begin
    take_d = 1'b0;
    vec_d  = 8'h00;
    if (settled && !TAKE_OUT) begin
      if (trap_ok && protect) begin
        take_d = 1'b1;
        vec_d  = `VEC_PROTECT;
      end else if (trap_ok && unaligned) begin
        take_d = 1'b1;
        vec_d  = `VEC_UNALIGNED;
      end else if (trap_ok && single_step_pending_q) begin
        take_d = 1'b1;
        vec_d  = `VEC_TRACE;
      end else if (en_timer) begin
        take_d = 1'b1;
        vec_d  = `VEC_TIMER;
      end else if (en_zero) begin
        take_d = 1'b1;
        vec_d  = `VEC_EXT_ZERO;
      end else if (en_two) begin
        take_d = 1'b1;
        vec_d  = `VEC_EXT_TWO;
      end else if (en_int) begin
        take_d = 1'b1;
        vec_d  = `VEC_INTERNAL;
      end
    end
  end

  wire [31:0] status = {14'h0000, timer_irq_block_q, 2'b00, irq_pending_flag_q,
                        single_step_enable_q, single_step_pending_q,
                        align_check_enable_q, state_hold_q, 2'b00, idle_wait_q,
                        2'b00, privileged_level_q, irq_priority_mask_q,
                        irq_block_q, irq_trap_block_all_q};

  // --------------------------------------------------------------------------
  // Registers
  // --------------------------------------------------------------------------
  always @(posedge CLK_SYS_IN or posedge RESET_IN) begin
    if (RESET_IN) begin
      timer_irq_block_q     <= 1'b0;
      irq_pending_flag_q    <= 1'b0;
      single_step_enable_q  <= 1'b0;
      single_step_pending_q <= 1'b0;
      align_check_enable_q  <= 1'b0;
      state_hold_q          <= 1'b1;
      idle_wait_q           <= 1'b0;
      privileged_level_q    <= 1'b1;
      irq_priority_mask_q   <= 2'b00;
      irq_block_q           <= 1'b1;
      irq_trap_block_all_q  <= 1'b1;
      release_cnt_q         <= 2'd0;
      TAKE_OUT              <= 1'b0;
      VECTOR_NUM_OUT        <= 8'h00;
      VECTOR_ADDR_OUT       <= 32'h00000000;
      STATE_HOLD_OUT        <= 1'b1;
      STALL_OUT             <= 1'b0;
      PSC_RDATA_OUT         <= `PSC_RESET_VALUE;
    end else begin
      irq_pending_flag_q <= pend_d;
      if (PSC_WRITE_IN) begin
        timer_irq_block_q    <= PSC_WDATA_IN[`PSC_BIT_TIMER_BLOCK];
        single_step_enable_q <= PSC_WDATA_IN[`PSC_BIT_STEP_EN];
        align_check_enable_q <= PSC_WDATA_IN[`PSC_BIT_ALIGN];
        idle_wait_q          <= PSC_WDATA_IN[`PSC_BIT_WAIT];
        privileged_level_q   <= PSC_WDATA_IN[`PSC_BIT_PRIV];
        irq_priority_mask_q  <= PSC_WDATA_IN[`PSC_BIT_MASK_HI:`PSC_BIT_MASK_LO];
        irq_block_q          <= PSC_WDATA_IN[`PSC_BIT_IRQ_BLOCK];
        irq_trap_block_all_q <= PSC_WDATA_IN[`PSC_BIT_BLOCK_ALL];
      end
      // Taking an event overrides a same-cycle software write of hold, wait, privilege and step pending
      if (take_d) begin
        state_hold_q       <= 1'b1;
        idle_wait_q        <= 1'b0;
        privileged_level_q <= 1'b1;
        single_step_pending_q <= 1'b0;
        release_cnt_q      <= 2'd0;
      end else begin
        if (PSC_WRITE_IN) begin
          state_hold_q <= PSC_WDATA_IN[`PSC_BIT_HOLD];
          if (state_hold_q && !PSC_WDATA_IN[`PSC_BIT_HOLD])
            release_cnt_q <= 2'd`HOLD_RELEASE_CYCLES;
          else if (release_cnt_q != 2'd0)
            release_cnt_q <= release_cnt_q - 2'd1;
        end else if (release_cnt_q != 2'd0) begin
          release_cnt_q <= release_cnt_q - 2'd1;
        end
        if (INSTR_DONE_IN && !idle_wait_q)
          single_step_pending_q <= single_step_enable_q;
        else if (PSC_WRITE_IN)
          single_step_pending_q <= PSC_WDATA_IN[`PSC_BIT_STEP_PEND];
      end
      TAKE_OUT        <= take_d;
      VECTOR_NUM_OUT  <= take_d ? vec_d : VECTOR_NUM_OUT;
      VECTOR_ADDR_OUT <= take_d ? vec_addr(VECTOR_BASE_IN, vec_d) : VECTOR_ADDR_OUT;
      // Hold to pipeline stays asserted while release_cnt_q is above one, dropping on the edge where release_cnt_q reaches zero, a cycle before TAKE_OUT can rise
      STATE_HOLD_OUT  <= take_d | state_hold_q |
                         (release_cnt_q > 2'd1);
      STALL_OUT       <= idle_wait_q && !take_d;
      PSC_RDATA_OUT   <= status;
    end
  end

endmodule

// ---- test/proc_status_gating_properties.sv ----
// Port-level checks for the status register and event gating block.
// Assumes one clock domain and the block's registered outputs.
`timescale 1ns/1ps
`include "proc_status_regs.vh"
module proc_status_gating_properties (
  input wire        CLK_SYS_IN, RESET_IN, PSC_WRITE_IN, EXT_IRQ_ZERO_IN, EXT_IRQ_TWO_IN,
  input wire        INT_IRQ_IN, TIMER_IRQ_IN, TIMER_RELOAD_IRQ_ENABLE_IN, INSTR_DONE_IN,
  input wire        DATA_ACCESS_IN, DATA_IO_IN, DATA_WORD_IN, DATA_HALF_IN,
  input wire        PROTECTED_ACCESS_IN, TAKE_OUT, STATE_HOLD_OUT, STALL_OUT,
  input wire [1:0]  DATA_ADDR_LO_IN,
  input wire [7:0]  VECTOR_NUM_OUT,
  input wire [31:0] PSC_WDATA_IN, PSC_RDATA_OUT, VECTOR_BASE_IN, VECTOR_ADDR_OUT
);
  default clocking @(posedge CLK_SYS_IN); endclocking
  default disable iff (RESET_IN);
  chk_take_spacing: assert property (TAKE_OUT |=> !TAKE_OUT)
    else $error("take pulse too long");
  chk_hold_on_take: assert property (TAKE_OUT |=> STATE_HOLD_OUT)
    else $error("hold not set by take");
  chk_hold_release: assert property (
    PSC_WRITE_IN && !PSC_WDATA_IN[10] && STATE_HOLD_OUT |=> !TAKE_OUT [*2])
    else $error("take too soon after hold release");
  chk_vector_addr: assert property (TAKE_OUT |->
    VECTOR_ADDR_OUT == {$past(VECTOR_BASE_IN[31:10]), VECTOR_NUM_OUT, 2'h0})
    else $error("vector address wrong");
  chk_vector_code: assert property (TAKE_OUT |-> VECTOR_NUM_OUT inside
    {8'h01, 8'h05, 8'h0E, 8'h0F, 8'h10, 8'h12, 8'h13}) else $error("bad vector");
  chk_block_all: assert property (
    TAKE_OUT && !$past(PSC_WRITE_IN) |=> !PSC_RDATA_OUT[0]) else $error("take under block");
  chk_protect_trap: assert property (PROTECTED_ACCESS_IN && !PSC_RDATA_OUT[4]
    && !PSC_RDATA_OUT[0] && !STATE_HOLD_OUT && !TAKE_OUT && !PSC_WRITE_IN
    && !$past(PSC_WRITE_IN) && !$past(PSC_WRITE_IN, 2) |=> TAKE_OUT
    && VECTOR_NUM_OUT == `VEC_PROTECT) else $error("protection trap missing");
  chk_unaligned_src: assert property (TAKE_OUT && VECTOR_NUM_OUT == `VEC_UNALIGNED
    |-> $past(DATA_ACCESS_IN) && !$past(DATA_IO_IN)) else $error("spurious unaligned trap");
  chk_stall_exit: assert property ($fell(STALL_OUT) |-> TAKE_OUT || $past(TAKE_OUT)
    || $past(PSC_WRITE_IN) || $past(PSC_WRITE_IN, 2)) else $error("wait left without cause");
  chk_pend_clear: assert property (
    (!EXT_IRQ_ZERO_IN && !EXT_IRQ_TWO_IN && !INT_IRQ_IN) [*3] |-> !PSC_RDATA_OUT[14])
    else $error("pending flag stuck");
endmodule
bind proc_status_gating proc_status_gating_properties u_proc_status_gating_properties (.*);

// ---- test/proc_pipeline_model.sv ----
// Pipeline stand-in that reports instruction completions.
// Assumes the bench clock; completions stop while the block stalls.
`timescale 1ns/1ps
module proc_pipeline_model (
  input  wire clk_in,
  input  wire stall_in,
  input  wire slow_in,
  output reg  done_out
);
  reg odd_q;
  initial begin
    done_out = 1'b0;
    odd_q = 1'b0;
  end
  // Slow mode stands for multi-cycle instructions
  always @(negedge clk_in) begin
    odd_q <= ~odd_q;
    done_out <= !stall_in && (!slow_in || odd_q);
  end
endmodule

// ---- test/tb_proc_status_gating.sv ----
// Self-checking bench for the status register and event gating block.
// Assumes inputs change on the falling edge; requests are levels.
`timescale 1ns/1ps
`include "proc_status_regs.vh"
module tb_proc_status_gating;
  reg         clk, rst, wr, slow;
  reg  [7:0]  src;
  reg  [31:0] wdata, base, seed;
  wire        done, take, hold, stall;
  wire [7:0]  vnum;
  wire [31:0] rdata, vaddr;
  integer     fail_count, samples_checked, cycles, i, m, k;
  proc_status_gating u_proc_status_gating (.CLK_SYS_IN(clk), .RESET_IN(rst),
    .PSC_WRITE_IN(wr), .PSC_WDATA_IN(wdata), .PSC_RDATA_OUT(rdata),
    .EXT_IRQ_ZERO_IN(src[2]), .EXT_IRQ_TWO_IN(src[1]), .INT_IRQ_IN(src[0]),
    .TIMER_IRQ_IN(src[3]), .TIMER_RELOAD_IRQ_ENABLE_IN(src[7]), .INSTR_DONE_IN(done),
    .DATA_ACCESS_IN(src[5]), .DATA_IO_IN(src[4]), .DATA_WORD_IN(1'b1), .DATA_HALF_IN(1'b0),
    .DATA_ADDR_LO_IN(2'h2), .PROTECTED_ACCESS_IN(src[6]), .VECTOR_BASE_IN(base),
    .TAKE_OUT(take), .VECTOR_NUM_OUT(vnum), .VECTOR_ADDR_OUT(vaddr),
    .STATE_HOLD_OUT(hold), .STALL_OUT(stall));
  proc_pipeline_model u_proc_pipeline_model (.clk_in(clk), .stall_in(stall),
    .slow_in(slow), .done_out(done));
  function [31:0] lfsr(input [31:0] x);
    lfsr = {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Which irq source (zero, two, internal) each mask value lets through
  function [7:0] mask_vec(input integer mv, input integer kv);
    mask_vec = (kv == 0) ? `VEC_EXT_ZERO : (kv == 1) ? ((mv >= 2) ? `VEC_EXT_TWO : 8'h00)
             : ((mv == 3) ? `VEC_INTERNAL : 8'h00);
  endfunction
  task check(input [31:0] seen, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (seen !== exp) begin
        fail_count = fail_count + 1;
        $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task summarize;
    begin
      $display("checks=%0d mismatches=%0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task write(input [31:0] v);
    begin
      wdata = v;
      wr = 1'b1;
      @(negedge clk);
      wr = 1'b0;
    end
  endtask
  // Write the status word, raise sources, expect one vector or none (8'h00)
  task trial(input [31:0] v, input [7:0] s, input [7:0] vec);
    begin
      base = seed;
      slow = seed[3];
      // Freeze first so every trial starts a fresh release window, and let a
      // trace left armed by the previous trial drain before the real write
      write(32'h411);
      repeat (2) @(negedge clk);
      write(v);
      src = s;
      i = 0;
      while (i < 10 && take !== 1'b1) begin
        @(negedge clk);
        i = i + 1;
      end
      check(take, vec != 8'h00);
      if (take === 1'b1) begin
        check(i >= 3, 1);
        check(vnum, vec);
        check(vaddr, {base[31:10], vec, 2'h0});
      end else check(rdata[14], |s[2:0]);
      src = 8'h00;
      repeat (4) @(negedge clk);
      check(rdata[14], 0);
      check(stall, v[7] && vec == 8'h00);
      check(hold, vec != 8'h00);
      seed = lfsr(seed);
      $display("trial psc=%h src=%h done", v, s);
    end
  endtask
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles == 3000) begin
      fail_count = fail_count + 1;
      summarize;
    end
  end
  initial begin
    rst = 1'b1;
    wr = 1'b0;
    slow = 1'b0;
    src = 8'h00;
    wdata = 32'h0;
    seed = 32'hB8932A92;
    base = 32'h0;
    fail_count = 0;
    samples_checked = 0;
    cycles = 0;
    repeat (5) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    check(rdata, `PSC_RESET_VALUE);
    check(hold, 1);
    for (k = 0; k < 40; k = k + 1) begin
      seed = lfsr(seed);
      write(seed & `PSC_WRITE_MASK & ~32'h3080 | 32'h401);
      repeat (2) @(posedge clk);
      @(negedge clk);
      check(rdata, seed & `PSC_WRITE_MASK & ~32'h3080 | 32'h401);
      check(hold, 1);
    end
    $display("random writes done");
    for (m = 0; m < 4; m = m + 1)
      for (k = 0; k < 3; k = k + 1)
        trial(32'h10 | (m << 2), 8'h04 >> k, mask_vec(m, k));
    trial(32'h12, 8'h04, 8'h00);
    trial(32'h12, 8'h88, `VEC_TIMER);
    trial(32'h20012, 8'h88, 8'h00);
    trial(32'h10, 8'h08, 8'h00);
    trial(32'h11, 8'h8F, 8'h00);
    trial(32'h810, 8'h20, `VEC_UNALIGNED);
    trial(32'h810, 8'h30, 8'h00);
    trial(32'h10, 8'h20, 8'h00);
    trial(32'h810, 8'h2C, `VEC_UNALIGNED);
    trial(32'h0, 8'h44, `VEC_PROTECT);
    trial(32'h2012, 8'h00, `VEC_TRACE);
    trial(32'h91, 8'h04, 8'h00);
    trial(32'h90, 8'h04, `VEC_EXT_ZERO);
    summarize;
  end
endmodule
